// >>> logic/ditd_pkg.sv
package ditd_pkg;
  localparam int NUM_TERM = 8;
  localparam int CODE_W = 6;
  localparam int FN_W = 26;
  // Highest accepted function code per terminal group
  localparam logic [5:0] CODE_MAX_LOW = 6'h2B;
  localparam logic [5:0] CODE_MAX_T7 = 6'h2F;
  localparam logic [5:0] CODE_MAX_T8 = 6'h30;
  // Function codes
  localparam int FN_SPD0 = 1;
  localparam int FN_RAMP0 = 4;
  localparam int FN_FLT_NO = 6;
  localparam int FN_FLT_NC = 7;
  localparam int FN_RESET = 8;
  localparam int FN_JOG_F = 9;
  localparam int FN_JOG_R = 10;
  localparam int FN_STOP = 11;
  localparam int FN_UP = 12;
  localparam int FN_LOWER = 13;
  localparam int FN_PLC_PAUSE = 14;
  localparam int FN_HOLD = 15;
  localparam int FN_3WIRE = 16;
  localparam int FN_XSTOP_NO = 17;
  localparam int FN_XSTOP_NC = 18;
  localparam int FN_DCB = 19;
  localparam int FN_NOLOOP = 20;
  localparam int FN_NOPLC = 21;
  localparam int FN_SRC0 = 22;
  localparam int FN_FORCE_CUR = 25;
  // Register byte offsets
  localparam logic [7:0] ADR_FSEL0 = 8'h00;
  localparam logic [7:0] ADR_CFG = 8'h20;
  localparam logic [7:0] ADR_SRC = 8'h24;
  localparam logic [7:0] ADR_BRK = 8'h28;
  localparam logic [7:0] ADR_STAT = 8'h2C;
  localparam logic [7:0] ADR_FLT = 8'h30;
  // Field positions
  localparam int CFG_LOOP_BIT = 0;
  localparam int CFG_PLC_BIT = 1;
  localparam int CFG_STOPM_LSB = 2;
  localparam int FLT_CLR_BIT = 0;
  localparam int FLT_ACT_BIT = 8;
  localparam int STAT_SRC_LSB = 26;
  localparam int STAT_FLT_BIT = 29;
  // Reset values
  localparam logic [5:0] FSEL_RST = 6'h00;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [2:0] SRC_RST = 3'h1;
  localparam logic [15:0] BRK_RST = 16'h0000;
  // Reference source encodings
  localparam logic [2:0] SRC_DIG1 = 3'h1;
  localparam logic [2:0] SRC_DIG3 = 3'h3;
  localparam logic [2:0] SRC_CUR = 3'h5;
  localparam logic [2:0] SRC_PULSE = 3'h6;
  localparam logic [7:0] FAULT_EXT_CODE = 8'h0F;
  // Braking time unit: one millisecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int BRK_UNIT_NS = 1000000;
  localparam int BRK_TICK_CYCLES = BRK_UNIT_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {FLT_OK = 2'b00, FLT_ON = 2'b01} ditd_flt_e;
  typedef enum logic [1:0] {BRK_IDLE = 2'b00, BRK_RUN = 2'b01, BRK_TAIL = 2'b11} ditd_brk_e;
endpackage : ditd_pkg

// >>> logic/ditd_sync.sv
`timescale 1ns/1ps
module ditd_sync
  import ditd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pin level in, settled level out
  input wire logic async_in,
  output logic sync_out
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  // Second stage is the only reader of the first
  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  // Two stages against contact metastability
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule : ditd_sync

// >>> logic/ditd_top.sv
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module ditd_top
  import ditd_pkg::*;
#(
  parameter int TICK_CYCLES = BRK_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Terminal pins and core status
  input wire logic [NUM_TERM-1:0] term_in,
  input wire logic decel_stop_in,
  // Speed and ramp selection
  output logic [2:0] multi_step_speed,
  output logic [1:0] ramp_set_sel,
  // Fault handling
  output logic fault_active,
  output logic [7:0] fault_code,
  output logic fault_clear_pulse,
  // Run commands
  output logic jog_forward_cmd,
  output logic jog_reverse_cmd,
  output logic remote_stop_cmd,
  output logic [1:0] stop_mode,
  output logic three_wire_stop,
  output logic freq_raise_cmd,
  output logic freq_lower_cmd,
  output logic plc_pause,
  output logic zero_freq_cmd,
  output logic flying_start,
  output logic ramp_hold,
  output logic dc_brake,
  // Mode and source
  output logic loop_bypass,
  output logic plc_bypass,
  output logic [2:0] ref_source
);
  logic [NUM_TERM-1:0] term_lvl;
  logic [NUM_TERM-1:0] term_act;
  logic [CODE_W-1:0] fsel_ff [NUM_TERM];
  logic [CODE_W-1:0] nxt_fsel [NUM_TERM];
  logic [FN_W-1:0] fn_c;
  logic [FN_W-1:0] fn_ff;
  logic [FN_W-1:0] fn_rise;
  logic [FN_W-1:0] fn_fall;

  // Synchronise and polarise each terminal
  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g++) begin : g_term
      ditd_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(term_in[g]),
        .sync_out(term_lvl[g])
      );
      // Normally-closed codes are active when the contact opens
      assign term_act[g] = term_lvl[g] ^ ((fsel_ff[g] == CODE_W'(FN_FLT_NC)) ||
                                          (fsel_ff[g] == CODE_W'(FN_XSTOP_NC)));
    end
  endgenerate

  // Function vector: any terminal carrying a code drives it
  always_comb begin
    fn_c = '0;
    for (int f = 1; f < FN_W; f++) begin
      for (int t = 0; t < NUM_TERM; t++) begin
        if (fsel_ff[t] == CODE_W'(f) && term_act[t]) begin
          fn_c[f] = 1'b1;
        end
      end
    end
  end

  assign fn_rise = fn_c & ~fn_ff;
  assign fn_fall = ~fn_c & fn_ff;

  // ---- Register bus ----
  logic wb_ack_ff;
  logic nxt_wb_ack;
  logic [31:0] wb_dat_ff;
  logic [31:0] nxt_wb_dat;
  logic [3:0] cfg_ff;
  logic [3:0] nxt_cfg;
  logic [2:0] srcp_ff;
  logic [2:0] nxt_srcp;
  logic [15:0] brk_ff;
  logic [15:0] nxt_brk;
  logic wr_go;
  logic sw_src_wr;
  logic sw_flt_clr;
  logic [31:0] wmask;
  logic [31:0] cur_word;
  logic [31:0] new_word;

  // Write lands on the edge that completes the cycle
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_ff;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign new_word = (cur_word & ~wmask) | (wb_dat_i & wmask);

  // Present word of the addressed register, also read data
  always_comb begin
    cur_word = 32'h0000_0000;
    case (wb_adr_i)
      ADR_CFG: cur_word = {28'h000_0000, cfg_ff};
      ADR_SRC: cur_word = {29'h0000_0000, srcp_ff};
      ADR_BRK: cur_word = {16'h0000, brk_ff};
      ADR_STAT: cur_word = {2'b00, fault_active, ref_source, fn_ff};
      ADR_FLT: cur_word = {23'h00_0000, fault_active, fault_code};
      default: begin
        if (wb_adr_i[7:5] == ADR_FSEL0[7:5] && wb_adr_i[1:0] == 2'b00) begin
          cur_word = {26'h000_0000, fsel_ff[wb_adr_i[4:2]]};
        end
      end
    endcase
  end

  // Register writes; out-of-range codes are refused
  always_comb begin
    nxt_wb_ack = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
    nxt_wb_dat = nxt_wb_ack ? cur_word : wb_dat_ff;
    nxt_cfg = cfg_ff;
    nxt_srcp = srcp_ff;
    nxt_brk = brk_ff;
    sw_src_wr = 1'b0;
    sw_flt_clr = 1'b0;
    for (int t = 0; t < NUM_TERM; t++) begin
      nxt_fsel[t] = fsel_ff[t];
    end
    if (wr_go) begin
      case (wb_adr_i)
        ADR_CFG: nxt_cfg = new_word[3:0];
        ADR_BRK: nxt_brk = new_word[15:0];
        ADR_SRC: begin
          if (new_word[2:0] >= SRC_DIG1 && new_word[2:0] <= SRC_PULSE) begin
            nxt_srcp = new_word[2:0];
            sw_src_wr = 1'b1;
          end
        end
        ADR_FLT: sw_flt_clr = wb_sel_i[0] & wb_dat_i[FLT_CLR_BIT];
        ADR_STAT: ;
        default: begin
          if (wb_adr_i[7:5] == ADR_FSEL0[7:5] && wb_adr_i[1:0] == 2'b00 &&
              new_word[31:6] == 26'h000_0000 &&
              new_word[5:0] <= (wb_adr_i[4:2] == 3'h7 ? CODE_MAX_T8 :
                                wb_adr_i[4:2] == 3'h6 ? CODE_MAX_T7 : CODE_MAX_LOW)) begin
            nxt_fsel[wb_adr_i[4:2]] = new_word[5:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
      cfg_ff <= CFG_RST;
      srcp_ff <= SRC_RST;
      brk_ff <= BRK_RST;
      for (int t = 0; t < NUM_TERM; t++) begin
        fsel_ff[t] <= FSEL_RST;
      end
    end else begin
      wb_ack_ff <= nxt_wb_ack;
      wb_dat_ff <= nxt_wb_dat;
      cfg_ff <= nxt_cfg;
      srcp_ff <= nxt_srcp;
      brk_ff <= nxt_brk;
      for (int t = 0; t < NUM_TERM; t++) begin
        fsel_ff[t] <= nxt_fsel[t];
      end
    end
  end

  // ---- Fault, source and braking state ----
  ditd_flt_e flt_ff;
  ditd_flt_e nxt_flt;
  ditd_brk_e brk_st_ff;
  ditd_brk_e nxt_brk_st;
  logic [2:0] src_ff;
  logic [2:0] nxt_src;
  logic [2:0] tsel;
  logic [15:0] brk_cnt_ff;
  logic [15:0] nxt_brk_cnt;
  logic [31:0] tick_cnt_ff;
  logic [31:0] nxt_tick_cnt;
  logic tick;

  assign tsel = fn_c[FN_SRC0+2:FN_SRC0];
  assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

  // Fault set beats a clear in the same cycle
  always_comb begin
    case (flt_ff)
      FLT_OK: nxt_flt = (fn_c[FN_FLT_NO] | fn_c[FN_FLT_NC]) ? FLT_ON : FLT_OK;
      FLT_ON: begin
        if (fn_c[FN_FLT_NO] | fn_c[FN_FLT_NC]) begin
          nxt_flt = FLT_ON;
        end else if (fn_rise[FN_RESET] | sw_flt_clr) begin
          nxt_flt = FLT_OK;
        end else begin
          nxt_flt = FLT_ON;
        end
      end
      default: nxt_flt = FLT_OK;
    endcase
  end

  // Latest of terminal selector change or parameter write wins
  always_comb begin
    nxt_src = src_ff;
    if (sw_src_wr) begin
      nxt_src = nxt_srcp;
    end
    if (tsel != fn_ff[FN_SRC0+2:FN_SRC0] && tsel != 3'h0) begin
      nxt_src = (tsel > SRC_PULSE) ? SRC_PULSE : tsel;
    end
  end

  // Brake runs while held, then for what is left of the set time
  always_comb begin
    nxt_tick_cnt = tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
    nxt_brk_cnt = brk_cnt_ff;
    nxt_brk_st = brk_st_ff;
    if (tick && brk_cnt_ff != 16'h0000) begin
      nxt_brk_cnt = brk_cnt_ff - 16'h0001;
    end
    case (brk_st_ff)
      BRK_IDLE: begin
        if (fn_rise[FN_DCB]) begin
          nxt_brk_st = BRK_RUN;
          nxt_brk_cnt = brk_ff;
          nxt_tick_cnt = 32'h0000_0000;
        end
      end
      BRK_RUN: begin
        if (!fn_c[FN_DCB]) begin
          nxt_brk_st = (nxt_brk_cnt == 16'h0000) ? BRK_IDLE : BRK_TAIL;
        end
      end
      BRK_TAIL: begin
        if (fn_rise[FN_DCB]) begin
          nxt_brk_st = BRK_RUN;
          nxt_brk_cnt = brk_ff;
          nxt_tick_cnt = 32'h0000_0000;
        end else if (nxt_brk_cnt == 16'h0000) begin
          nxt_brk_st = BRK_IDLE;
        end
      end
      default: nxt_brk_st = BRK_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fn_ff <= '0;
      flt_ff <= FLT_OK;
      src_ff <= SRC_RST;
      brk_st_ff <= BRK_IDLE;
      brk_cnt_ff <= 16'h0000;
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      fn_ff <= fn_c;
      flt_ff <= nxt_flt;
      src_ff <= nxt_src;
      brk_st_ff <= nxt_brk_st;
      brk_cnt_ff <= nxt_brk_cnt;
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // ---- Registered outputs ----
  logic [31:0] out_ff;
  logic [31:0] nxt_out;
  logic [2:0] src_out_ff;
  logic [2:0] nxt_src_out;
  logic dig_src;

  // Up/down only makes sense on a digital setting
  assign dig_src = (src_ff >= SRC_DIG1) && (src_ff <= SRC_DIG3) && !fn_c[FN_FORCE_CUR];

  always_comb begin
    nxt_out = 32'h0000_0000;
    nxt_out[2:0] = fn_c[FN_SPD0+2:FN_SPD0];
    nxt_out[4:3] = fn_c[FN_RAMP0+1:FN_RAMP0];
    nxt_out[5] = (nxt_flt == FLT_ON);
    nxt_out[29:22] = (nxt_flt == FLT_ON) ? FAULT_EXT_CODE : 8'h00;
    nxt_out[6] = (flt_ff == FLT_ON) && (nxt_flt == FLT_OK);
    nxt_out[7] = fn_c[FN_JOG_F];
    nxt_out[8] = fn_c[FN_JOG_R];
    nxt_out[9] = fn_c[FN_STOP];
    nxt_out[10] = fn_c[FN_3WIRE];
    nxt_out[11] = fn_c[FN_UP] & dig_src;
    nxt_out[12] = fn_c[FN_LOWER] & dig_src;
    nxt_out[13] = fn_c[FN_PLC_PAUSE];
    // No alarm path from external stop: it zeroes the output and gives a flying start on release
    nxt_out[14] = fn_c[FN_PLC_PAUSE] | fn_c[FN_XSTOP_NO] | fn_c[FN_XSTOP_NC];
    nxt_out[15] = fn_fall[FN_PLC_PAUSE] |
                  ((fn_ff[FN_XSTOP_NO] | fn_ff[FN_XSTOP_NC]) &
                   ~(fn_c[FN_XSTOP_NO] | fn_c[FN_XSTOP_NC]));
    nxt_out[16] = fn_c[FN_HOLD] & ~decel_stop_in;
    nxt_out[17] = fn_c[FN_DCB] | (nxt_brk_st != BRK_IDLE);
    nxt_out[18] = fn_c[FN_NOLOOP] & cfg_ff[CFG_LOOP_BIT];
    nxt_out[19] = fn_c[FN_NOPLC] & cfg_ff[CFG_PLC_BIT];
    nxt_out[21:20] = cfg_ff[CFG_STOPM_LSB+1:CFG_STOPM_LSB];
    nxt_src_out = fn_c[FN_FORCE_CUR] ? SRC_CUR : nxt_src;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_ff <= 32'h0000_0000;
      src_out_ff <= SRC_RST;
    end else begin
      out_ff <= nxt_out;
      src_out_ff <= nxt_src_out;
    end
  end

  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign multi_step_speed = out_ff[2:0];
  assign ramp_set_sel = out_ff[4:3];
  assign fault_active = out_ff[5];
  assign fault_code = out_ff[29:22];
  assign fault_clear_pulse = out_ff[6];
  assign jog_forward_cmd = out_ff[7];
  assign jog_reverse_cmd = out_ff[8];
  assign remote_stop_cmd = out_ff[9];
  assign three_wire_stop = out_ff[10];
  assign freq_raise_cmd = out_ff[11];
  assign freq_lower_cmd = out_ff[12];
  assign plc_pause = out_ff[13];
  assign zero_freq_cmd = out_ff[14];
  assign flying_start = out_ff[15];
  assign ramp_hold = out_ff[16];
  assign dc_brake = out_ff[17];
  assign loop_bypass = out_ff[18];
  assign plc_bypass = out_ff[19];
  assign stop_mode = out_ff[21:20];
  assign ref_source = src_out_ff;

  // ---- Checks ----
  chk_speed_sel: assert property (@(posedge sys_clk) disable iff (rst)
    multi_step_speed == $past(fn_c[3:1])) else $error("speed select mismatch");
  chk_ramp_sel: assert property (@(posedge sys_clk) disable iff (rst)
    ramp_set_sel == $past(fn_c[5:4])) else $error("ramp select mismatch");
  chk_fault_set: assert property (@(posedge sys_clk) disable iff (rst)
    (fn_c[6] | fn_c[7]) |=> fault_active && fault_code == 8'h0F) else $error("fault not set");
  chk_fault_clear: assert property (@(posedge sys_clk) disable iff (rst)
    fault_active && !(fn_c[6] | fn_c[7]) && fn_rise[8] |=> !fault_active)
    else $error("reset did not clear fault");
  chk_jog_cmds: assert property (@(posedge sys_clk) disable iff (rst)
    fn_c[9] && !fn_c[10] |=> jog_forward_cmd && !jog_reverse_cmd) else $error("jog mismatch");
  chk_remote_stop: assert property (@(posedge sys_clk) disable iff (rst)
    fn_c[11] |=> remote_stop_cmd) else $error("remote stop missed");
  chk_updn_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (freq_raise_cmd | freq_lower_cmd) |-> $past(dig_src)) else $error("up/down not gated");
  chk_plc_pause: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(plc_pause) |-> flying_start) else $error("no flying start after pause");
  chk_ramp_hold: assert property (@(posedge sys_clk) disable iff (rst)
    $past(decel_stop_in) |-> !ramp_hold) else $error("hold during decel stop");
  chk_three_wire: assert property (@(posedge sys_clk) disable iff (rst)
    fn_c[16] |=> three_wire_stop) else $error("three-wire stop missed");
  chk_ext_stop: assert property (@(posedge sys_clk) disable iff (rst)
    (fn_c[17] | fn_c[18]) && !fault_active && !(fn_c[6] | fn_c[7]) |=>
    zero_freq_cmd && !fault_active)
    else $error("external stop raised fault or kept output");
  chk_brake_min: assert property (@(posedge sys_clk) disable iff (rst)
    fn_rise[19] && int'(brk_ff) * TICK_CYCLES >= 8 |=> dc_brake [*8])
    else $error("brake ended early");
  chk_loop_bypass: assert property (@(posedge sys_clk) disable iff (rst)
    loop_bypass |-> $past(cfg_ff[0])) else $error("loop bypass without closed loop");
  chk_plc_bypass: assert property (@(posedge sys_clk) disable iff (rst)
    plc_bypass |-> $past(cfg_ff[1])) else $error("PLC bypass without PLC");
  chk_src_select: assert property (@(posedge sys_clk) disable iff (rst)
    tsel == 3'h4 && fn_ff[24:22] != 3'h4 && !fn_c[25] |=> ref_source == 3'h4)
    else $error("terminal source not taken");
  chk_src_latest: assert property (@(posedge sys_clk) disable iff (rst)
    sw_src_wr && tsel == fn_ff[24:22] && !fn_c[25] |=> ref_source == $past(nxt_srcp))
    else $error("parameter write not followed");
  chk_force_cur: assert property (@(posedge sys_clk) disable iff (rst)
    fn_c[25] |=> ref_source == 3'h5) else $error("current input not forced");
  chk_code_range: assert property (@(posedge sys_clk) disable iff (rst)
    fsel_ff[0] <= 6'h2B && fsel_ff[6] <= 6'h2F && fsel_ff[7] <= 6'h30)
    else $error("code out of range");
  chk_wb_ack: assert property (@(posedge sys_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  cov_fault_cycle: cover property (@(posedge sys_clk) disable iff (rst)
    fault_active ##[1:200] fault_clear_pulse);
  cov_brake_tail: cover property (@(posedge sys_clk) disable iff (rst)
    brk_st_ff == BRK_TAIL);
  cov_force_cur: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(fn_c[25]));
  cov_flying: cover property (@(posedge sys_clk) disable iff (rst) flying_start);
endmodule : ditd_top

// >>> tb/ditd_switches.sv
`timescale 1ns/1ps
// Contact bank: a press asserts the function; NC contacts open when pressed
module ditd_switches (
  // Commanded presses and contact kinds
  input wire logic [7:0] press,
  input wire logic [7:0] nc_mask,
  // Terminal pins, high = contact closed
  output logic [7:0] term_in
);
  // NC contacts idle closed, so an idle NC pin reads high
  assign term_in = press ^ nc_mask;
endmodule : ditd_switches

// >>> tb/tb_ditd_top.sv
`timescale 1ns/1ps
module tb_ditd_top;
  import ditd_pkg::*;
  logic sys_clk, rst, cyc, stb, we, decel, ack;
  logic fact, fclr, jf, jr, rs, tw, fr, fl, pp, zf, fs, rh, dcb, lb, pb;
  logic [7:0] adr, press, nc_mask, term, fcode;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, dat_o;
  logic [2:0] mss, src;
  logic [1:0] rsel, smode;
  int mismatches, check_count;
  // {cfg, terminal, code, expected outputs} per function
  localparam logic [31:0] TBL [16] = '{32'h0009_0800, 32'h000A_0400, 32'h000B_0200,
    32'hC00B_0200, 32'h0010_0100, 32'h000E_00A0, 32'h000F_0040, 32'h0011_0020,
    32'h0612_0020, 32'h0013_0001, 32'h000C_0010, 32'h000D_0008, 32'h0014_0000,
    32'h0015_0000, 32'h1014_0004, 32'h2015_0002};

  ditd_switches SW (.press(press), .nc_mask(nc_mask), .term_in(term));

  ditd_top #(.TICK_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .term_in(term), .decel_stop_in(decel),
    .multi_step_speed(mss), .ramp_set_sel(rsel), .fault_active(fact), .fault_code(fcode),
    .fault_clear_pulse(fclr), .jog_forward_cmd(jf), .jog_reverse_cmd(jr),
    .remote_stop_cmd(rs), .stop_mode(smode), .three_wire_stop(tw), .freq_raise_cmd(fr),
    .freq_lower_cmd(fl), .plc_pause(pp), .zero_freq_cmd(zf), .flying_start(fs),
    .ramp_hold(rh), .dc_brake(dcb), .loop_bypass(lb), .plc_bypass(pb), .ref_source(src));

  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Classic single cycle; waits for ack under a bound, since latency is not assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 20) begin
        mismatches++;
        results();
      end
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk("register", exp, rdat);
  endtask : rdc

  task automatic fsel(input int t, input logic [5:0] c);
    bus(1'b1, ADR_FSEL0 + 8'(4 * t), 32'(c));
  endtask : fsel

  // Presses change just after an edge; levels and pulses land three edges later
  task automatic act(input logic [7:0] p);
    @(posedge sys_clk);
    press <= p;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : act

  // Main sequence
  initial begin
    logic [31:0] e;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    press = 8'h00;
    nc_mask = 8'h40;
    decel = 1'b0;
    mismatches = 0;
    check_count = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("ref_source", 32'h0000_0001, 32'(src));
    bus(1'b1, ADR_SRC, 32'h0000_0007);
    rdc(ADR_SRC, 32'h0000_0001);
    rdc(8'hFC, 32'h0000_0000);
    bus(1'b1, ADR_FSEL0, 32'h0000_002C);
    rdc(ADR_FSEL0, 32'h0000_0000);
    fsel(7, 6'h30);
    rdc(ADR_FSEL0 + 8'h1C, 32'h0000_0030);
    fsel(7, 6'h31);
    rdc(ADR_FSEL0 + 8'h1C, 32'h0000_0030);
    fsel(7, 6'h00);
    // Speed and ramp selectors, every pattern
    fsel(0, 6'h01);
    fsel(1, 6'h02);
    fsel(2, 6'h03);
    for (int v = 0; v < 8; v++) begin
      act(8'(v));
      chk("speed", 32'(v), 32'(mss));
    end
    act(8'h00);
    fsel(0, 6'h04);
    fsel(1, 6'h05);
    fsel(2, 6'h00);
    for (int v = 0; v < 4; v++) begin
      act(8'(v));
      chk("ramp", 32'(v), 32'(rsel));
    end
    act(8'h00);
    // External fault NO and NC, cleared by terminal and by register
    fsel(5, 6'h06);
    fsel(6, 6'h07);
    fsel(7, 6'h08);
    act(8'h20);
    chk("fault", 32'h0000_010F, {23'h0, fact, fcode});
    act(8'h00);
    chk("fault held", 32'h0000_0001, 32'(fact));
    act(8'h80);
    chk("fault clr", 32'h0000_0001, {30'h0, fact, fclr});
    @(posedge sys_clk);
    #1;
    chk("clr pulse", 32'h0000_0000, 32'(fclr));
    act(8'h40);
    chk("fault nc", 32'h0000_0001, 32'(fact));
    act(8'h00);
    bus(1'b1, ADR_FLT, 32'h0000_0001);
    rdc(ADR_FLT, 32'h0000_0000);
    for (int t = 5; t < 8; t++) fsel(t, 6'h00);
    // One function at a time, with its gating configuration
    for (int i = 0; i < 16; i++) begin
      e = TBL[i];
      bus(1'b1, ADR_CFG, 32'(e[31:28]));
      fsel(int'(e[27:24]), e[21:16]);
      act(8'h01 << e[27:24]);
      chk("outputs", 32'(e[11:0]), {20'h0, jf, jr, rs, tw, pp, rh, zf, fr, fl, lb, pb, dcb});
      chk("stop_mode", 32'(e[31:30]), 32'(smode));
      act(8'h00);
      fsel(int'(e[27:24]), 6'h00);
    end
    rdc(ADR_CFG, 32'h0000_0002);
    // Release of pause and of external stop gives one flying-start pulse
    for (int c = 14; c <= 17; c += 3) begin
      fsel(0, 6'(c));
      act(8'h01);
      act(8'h00);
      chk("flying", 32'h0000_0001, 32'(fs));
      @(posedge sys_clk);
      #1;
      chk("flying end", 32'h0000_0000, 32'(fs));
    end
    // Ramp hold is void during decelerate-to-stop
    fsel(0, 6'h0F);
    @(posedge sys_clk);
    decel <= 1'b1;
    act(8'h01);
    chk("hold decel", 32'h0000_0000, 32'(rh));
    act(8'h00);
    decel <= 1'b0;
    // Two terminals on one code are ORed
    fsel(0, 6'h09);
    fsel(1, 6'h09);
    act(8'h02);
    chk("or jog", 32'h0000_0001, 32'(jf));
    act(8'h00);
    fsel(1, 6'h00);
    // Reference selector, latest of parameter write and terminal change wins, forced current input
    fsel(0, 6'h16);
    fsel(1, 6'h17);
    fsel(2, 6'h18);
    for (int v = 1; v < 9; v++) begin
      act(8'(v % 8));
      chk("source", (v > 5) ? 32'h0000_0006 : 32'(v), 32'(src));
    end
    bus(1'b1, ADR_SRC, 32'h0000_0002);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("source param", 32'h0000_0002, 32'(src));
    act(8'h03);
    chk("source term", 32'h0000_0003, 32'(src));
    fsel(3, 6'h19);
    fsel(4, 6'h0C);
    act(8'h1B);
    chk("forced cur", 32'(SRC_CUR), 32'(src));
    chk("up gated", 32'h0000_0000, 32'(fr));
    rdc(ADR_STAT, 32'h16C0_1000);
    act(8'h03);
    chk("restored", 32'h0000_0003, 32'(src));
    act(8'h00);
    for (int t = 0; t < 5; t++) fsel(t, 6'h00);
    // Braking: 2 ticks of 4 cycles is 8 cycles; a short touch still brakes, a long hold outlasts it
    fsel(0, 6'h13);
    bus(1'b1, ADR_BRK, 32'h0000_0002);
    @(posedge sys_clk);
    press <= 8'h01;
    @(posedge sys_clk);
    press <= 8'h00;
    repeat (5) @(posedge sys_clk);
    #1;
    chk("brake time", 32'h0000_0001, 32'(dcb));
    repeat (12) @(posedge sys_clk);
    #1;
    chk("brake end", 32'h0000_0000, 32'(dcb));
    act(8'h01);
    repeat (20) @(posedge sys_clk);
    #1;
    chk("brake held", 32'h0000_0001, 32'(dcb));
    act(8'h00);
    chk("brake off", 32'h0000_0000, 32'(dcb));
    results();
  end
endmodule : tb_ditd_top
